// [verilog/rct_pkg.sv]
// Register map, fields, scale tables and timing of the ripple counter
package rct_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] RCT_OFF_CTRL = 8'h00;
    localparam logic [7:0] RCT_OFF_MODEL = 8'h04;
    localparam logic [7:0] RCT_OFF_FILTER = 8'h08;
    localparam logic [7:0] RCT_OFF_CORR = 8'h0C;
    localparam logic [7:0] RCT_OFF_THRESH = 8'h10;
    localparam logic [7:0] RCT_OFF_COUNT = 8'h14;
    localparam logic [7:0] RCT_OFF_STATUS = 8'h18;
    localparam logic [7:0] RCT_OFF_NRT = 8'h1C;

    // CTRL field positions
    localparam int RCT_CTRL_ENABLE = 0;
    localparam int RCT_CTRL_CORR_DIS = 1;
    localparam int RCT_CTRL_OUT_GATE = 2;
    localparam int RCT_CTRL_VSNS = 3;
    localparam int RCT_CTRL_REP_LSB = 4;
    localparam int RCT_CTRL_STALL = 6;
    localparam int RCT_CTRL_CLEAR = 8;

    // MODEL, FILTER, CORR, THRESH field positions
    localparam int RCT_COND_LSB = 0;
    localparam int RCT_COND_SCALE_LSB = 8;
    localparam int RCT_BEMF_LSB = 16;
    localparam int RCT_BEMF_SCALE_LSB = 24;
    localparam int RCT_BPQ_LSB = 0;
    localparam int RCT_BPGAIN_LSB = 8;
    localparam int RCT_MECH_LSB = 16;
    localparam int RCT_OUTFLT_LSB = 24;
    localparam int RCT_BLANK_LSB = 0;
    localparam int RCT_MISS_LSB = 2;
    localparam int RCT_THR_LSB = 0;
    localparam int RCT_THR_SCALE_LSB = 8;

    // Reset values
    localparam logic [31:0] RCT_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RCT_MODEL_RST = 32'h0000_0000;
    localparam logic [31:0] RCT_FILTER_RST = 32'h0000_0000;
    localparam logic [31:0] RCT_CORR_RST = 32'h0000_0000;
    localparam logic [31:0] RCT_THRESH_RST = 32'h0000_0000;

    // Counter limits
    localparam logic [15:0] RCT_COUNT_MAX = 16'hFFFF;
    localparam logic [3:0] RCT_MUTE_RUN = 4'hC;

    // Pulse timing: 50 us at a 20 ns clock
    localparam int RCT_CLK_PERIOD_NS = 20;
    localparam int RCT_PULSE_TIME_NS = 50000;
    localparam int RCT_PULSE_CYCLES = RCT_PULSE_TIME_NS / RCT_CLK_PERIOD_NS;

    // Report selections
    localparam logic [1:0] RCT_REP_HOLD = 2'b00;
    localparam logic [1:0] RCT_REP_WRAP = 2'b01;
    localparam logic [1:0] RCT_REP_FAULT_THR = 2'b10;
    localparam logic [1:0] RCT_REP_FAULT_WRAP = 2'b11;

    // Control bits carried together
    typedef struct packed {
        logic stall_response_select;
        logic [1:0] count_report_select;
        logic voltage_sense_select;
        logic corrector_output_gate;
        logic correction_disable;
        logic ripple_count_enable;
    } rct_ctrl_s;

    // Decoded model scaling for the estimator
    typedef struct packed {
        logic [13:0] conductance_mult;
        logic [17:0] backemf_mult;
        logic [4:0] bandpass_gain_mult;
    } rct_scale_s;

    // Threshold scale: 2, 8, 16, 64
    function automatic logic [6:0] rct_thr_mult(input logic [1:0] code);
        case (code)
            2'b00: rct_thr_mult = 7'h02;
            2'b01: rct_thr_mult = 7'h08;
            2'b10: rct_thr_mult = 7'h10;
            default: rct_thr_mult = 7'h40;
        endcase
    endfunction

    // Conductance scale: 2, 64, 1024, 8192
    function automatic logic [13:0] rct_cond_mult(input logic [1:0] code);
        case (code)
            2'b00: rct_cond_mult = 14'h0002;
            2'b01: rct_cond_mult = 14'h0040;
            2'b10: rct_cond_mult = 14'h0400;
            default: rct_cond_mult = 14'h2000;
        endcase
    endfunction

    // Back-emf scale: 24 times 2^8, 2^9, 2^12, 2^13
    function automatic logic [17:0] rct_bemf_mult(input logic [1:0] code);
        case (code)
            2'b00: rct_bemf_mult = 18'h0_1800;
            2'b01: rct_bemf_mult = 18'h0_3000;
            2'b10: rct_bemf_mult = 18'h1_8000;
            default: rct_bemf_mult = 18'h3_0000;
        endcase
    endfunction

    // Band-pass gain: 2, 4, 8, 16
    function automatic logic [4:0] rct_gain_mult(input logic [1:0] code);
        case (code)
            2'b00: rct_gain_mult = 5'h02;
            2'b01: rct_gain_mult = 5'h04;
            2'b10: rct_gain_mult = 5'h08;
            default: rct_gain_mult = 5'h10;
        endcase
    endfunction

endpackage

// [verilog/rct_pulse_timer.sv]
// Retriggerable fixed-length pulse generator
`timescale 1ns/10ps
module rct_pulse_timer
    import rct_pkg::*;
#(
    parameter int LEN = RCT_PULSE_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic trig,
    output logic busy
);

    logic [11:0] left_reg;

    // Load on trigger, count down to zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            left_reg <= 12'h000;
            busy <= 1'b0;
        end
        else if (trig)
        begin
            left_reg <= 12'(LEN - 1);
            busy <= 1'b1;
        end
        else if (left_reg != 12'h000)
        begin
            left_reg <= left_reg - 12'h001;
        end
        else
        begin
            busy <= 1'b0;
        end
    end

endmodule

// [verilog/rct_ripple_counter.sv]
// Ripple counter configuration, error corrector, count, threshold and pin logic
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Ripples are kept in a software-readable 16-bit count.
// R2 - Threshold flag latches once count exceeds setting times scale.
// R3 - Threshold scale codes 00..11 mean 2, 8, 16, 64.
// R4 - Clear-count write of 1 zeroes count and threshold flag.
// R5 - Report selection decides if fault goes low on threshold.
// R6 - Conductance scale codes 00..11 mean 2, 64, 1024, 8192.
// R7 - Conductance value is an 8-bit integer, at most 255.
// R8 - Back-emf scale codes mean 24 times 2^8, 2^9, 2^12, 2^13.
// R9 - Band-pass gain codes 00..11 mean 2, 4, 8, 16.
// R10 - Voltage sense bit picks analog filter at 0, digital duty estimate at 1.
// R11 - Correction disable at 1 stops corrector and pulse pin.
// R12 - Gate at 0 keeps pulses flowing with motor stopped.
// R13 - Gate at 1 mutes pulses after 12 inserted pulses without a filter pulse.
// R14 - Blanking window after a ripple drops extra pulses.
// R15 - No pulse by end of miss window: corrector inserts one.
// R16 - One 50 us positive open-drain pulse per counted ripple.
// R17 - Mechanical low-pass setting sets counter response time.
// R18 - Filter damping setting sets the band-pass quality factor.
// R19 - Threshold settings never change the ripple count itself.
// R20 - Counting happens only while the count enable bit is 1.
// R21 - At maximum: hold for codes 00/10, wrap for 01/11; 11 pulses fault 50 us.
// R22 - Count advances once per pulse leaving the corrector.
module rct_ripple_counter
    import rct_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bandpass_pulse,
    input wire logic [15:0] ripple_period,
    output logic ripple_pulse_out_o,
    output logic ripple_pulse_out_oe,
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe,
    output rct_ctrl_s ctrl_out,
    output rct_scale_s scale_out,
    output logic [7:0] motor_conductance,
    output logic [7:0] backemf_constant,
    output logic [7:0] bandpass_q,
    output logic [7:0] mech_lowpass,
    output logic [7:0] output_filter_cutoff
);

    rct_ctrl_s ctrl_reg;
    logic [31:0] model_reg;
    logic [31:0] filter_reg;
    logic [3:0] corr_reg;
    logic [9:0] thresh_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic reached_reg;
    logic reached_next;
    logic [13:0] nrt_reg;
    logic clear_cmd;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_data;
    logic [15:0] since_reg;
    logic [16:0] blank_len;
    logic [16:0] miss_len;
    logic [17:0] miss_at;
    logic real_pulse;
    logic insert_pulse;
    logic corr_pulse;
    logic count_event;
    logic [3:0] insert_run_reg;
    logic muted_reg;
    logic at_max;
    logic wrap_event;
    logic rip_busy;
    logic wrap_busy;

    // APB decode: transfers complete in the second access cycle
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready && !pwrite;
    assign clear_cmd = wr_en && (paddr == RCT_OFF_CTRL) && pwdata[RCT_CTRL_CLEAR];

    // Address map check
    always_comb
    begin
        case (paddr)
            RCT_OFF_CTRL, RCT_OFF_MODEL, RCT_OFF_FILTER, RCT_OFF_CORR,
            RCT_OFF_THRESH, RCT_OFF_COUNT, RCT_OFF_STATUS, RCT_OFF_NRT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read multiplexer
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (paddr)
            RCT_OFF_CTRL: rd_data = {25'h0, ctrl_reg};
            RCT_OFF_MODEL: rd_data = model_reg;
            RCT_OFF_FILTER: rd_data = filter_reg;
            RCT_OFF_CORR: rd_data = {28'h0, corr_reg};
            RCT_OFF_THRESH: rd_data = {22'h0, thresh_reg};
            // R1 count readback
            RCT_OFF_COUNT: rd_data = {16'h0000, count_reg};
            RCT_OFF_STATUS: rd_data = {30'h0, muted_reg, reached_reg};
            RCT_OFF_NRT: rd_data = {18'h0, nrt_reg};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Bus answer: one wait state, error on unmapped address
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= rd_en ? rd_data : 32'h0000_0000;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register; clear bit never stored
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= rct_ctrl_s'(RCT_CTRL_RST[6:0]);
        end
        else if (wr_en && paddr == RCT_OFF_CTRL)
        begin
            ctrl_reg <= rct_ctrl_s'(pwdata[6:0]);
        end
    end

    // Model, filter, corrector and threshold settings
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            model_reg <= RCT_MODEL_RST;
            filter_reg <= RCT_FILTER_RST;
            corr_reg <= RCT_CORR_RST[3:0];
            thresh_reg <= RCT_THRESH_RST[9:0];
        end
        else if (wr_en)
        begin
            case (paddr)
                // R7 conductance kept as 8-bit integer
                RCT_OFF_MODEL: model_reg <= pwdata & 32'h03FF_03FF;
                RCT_OFF_FILTER: filter_reg <= pwdata & 32'hFFFF_03FF;
                RCT_OFF_CORR: corr_reg <= pwdata[3:0];
                RCT_OFF_THRESH: thresh_reg <= pwdata[9:0];
                default: ;
            endcase
        end
    end

    // Settings and decoded scales to the estimator
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_out <= rct_ctrl_s'(RCT_CTRL_RST[6:0]);
            scale_out <= '0;
            motor_conductance <= 8'h00;
            backemf_constant <= 8'h00;
            bandpass_q <= 8'h00;
            mech_lowpass <= 8'h00;
            output_filter_cutoff <= 8'h00;
        end
        else
        begin
            // R10 voltage sense select passed out
            ctrl_out <= ctrl_reg;
            // R6 conductance scale
            scale_out.conductance_mult <= rct_cond_mult(model_reg[RCT_COND_SCALE_LSB +: 2]);
            // R8 back-emf scale
            scale_out.backemf_mult <= rct_bemf_mult(model_reg[RCT_BEMF_SCALE_LSB +: 2]);
            // R9 band-pass gain
            scale_out.bandpass_gain_mult <= rct_gain_mult(filter_reg[RCT_BPGAIN_LSB +: 2]);
            motor_conductance <= model_reg[RCT_COND_LSB +: 8];
            backemf_constant <= model_reg[RCT_BEMF_LSB +: 8];
            // R18 band-pass quality factor
            bandpass_q <= filter_reg[RCT_BPQ_LSB +: 8];
            // R17 counter response time
            mech_lowpass <= filter_reg[RCT_MECH_LSB +: 8];
            output_filter_cutoff <= filter_reg[RCT_OUTFLT_LSB +: 8];
        end
    end

    // Window lengths in eighths of the expected ripple interval
    assign blank_len = 17'(({1'b0, ripple_period} >> 3) * (17'(corr_reg[RCT_BLANK_LSB +: 2]) + 17'h0_0001));
    assign miss_len = 17'(({1'b0, ripple_period} >> 3) * (17'(corr_reg[RCT_MISS_LSB +: 2]) + 17'h0_0001));
    assign miss_at = {2'b00, ripple_period} + {1'b0, miss_len};

    // R14 filter pulses inside the blanking window are extra
    assign real_pulse = bandpass_pulse && ({1'b0, since_reg} >= blank_len);
    // R15 no filter pulse by end of miss window: insert one
    assign insert_pulse = !bandpass_pulse && ({2'b00, since_reg} >= miss_at) && (ripple_period != 16'h0000);
    assign corr_pulse = real_pulse || insert_pulse;
    // R11 corrector off: raw pulses counted, pin silent
    // R22 count follows corrector output
    assign count_event = ctrl_reg.ripple_count_enable &&
        (ctrl_reg.correction_disable ? bandpass_pulse : corr_pulse);

    // Time since last accepted ripple, saturating
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            since_reg <= 16'h0000;
        end
        else if (!ctrl_reg.ripple_count_enable || corr_pulse)
        begin
            since_reg <= 16'h0000;
        end
        else if (since_reg != 16'hFFFF)
        begin
            since_reg <= since_reg + 16'h0001;
        end
    end

    // R13 inserted-pulse run; a filter pulse ends it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            insert_run_reg <= 4'h0;
            muted_reg <= 1'b0;
        end
        else if (!ctrl_reg.ripple_count_enable || bandpass_pulse)
        begin
            insert_run_reg <= 4'h0;
            muted_reg <= 1'b0;
        end
        else if (insert_pulse && insert_run_reg != RCT_MUTE_RUN)
        begin
            insert_run_reg <= insert_run_reg + 4'h1;
            muted_reg <= (insert_run_reg + 4'h1 == RCT_MUTE_RUN) && ctrl_reg.corrector_output_gate;
        end
        else if (insert_run_reg == RCT_MUTE_RUN)
        begin
            // R12 gate off never mutes
            muted_reg <= ctrl_reg.corrector_output_gate;
        end
    end

    // R21 maximum handling: hold or wrap by report code
    assign at_max = (count_reg == RCT_COUNT_MAX);
    assign wrap_event = count_event && at_max && ctrl_reg.count_report_select[0];

    always_comb
    begin
        count_next = count_reg;
        // R4 clear command zeroes the count
        if (clear_cmd)
        begin
            count_next = 16'h0000;
        end
        // R20 enable folded into count_event
        if (count_event)
        begin
            if (!at_max)
            begin
                count_next = (clear_cmd ? 16'h0000 : count_reg) + 16'h0001;
            end
            else if (ctrl_reg.count_report_select[0])
            begin
                count_next = 16'h0000;
            end
            else if (clear_cmd)
            begin
                count_next = 16'h0001;
            end
        end
    end

    // R1 ripple count register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= 16'h0000;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    // R3 threshold in ripples; R19 it only feeds the flag
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nrt_reg <= 14'h0000;
        end
        else
        begin
            nrt_reg <= 14'(thresh_reg[RCT_THR_LSB +: 8] * rct_thr_mult(thresh_reg[RCT_THR_SCALE_LSB +: 2]));
        end
    end

    // R2 sticky flag, set wins over clear
    assign reached_next = (count_next > {2'b00, nrt_reg}) || (reached_reg && !clear_cmd);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reached_reg <= 1'b0;
        end
        else
        begin
            reached_reg <= reached_next;
        end
    end

    // R16 50 us pin pulse per corrector pulse
    rct_pulse_timer #(
        .LEN(RCT_PULSE_CYCLES)
    ) u_rip_timer (
        .clk(clk),
        .rstn(rstn),
        .trig(count_event && !ctrl_reg.correction_disable && !muted_reg),
        .busy(rip_busy)
    );

    // R21 50 us fault pulse on wrap in code 11
    rct_pulse_timer #(
        .LEN(RCT_PULSE_CYCLES)
    ) u_wrap_timer (
        .clk(clk),
        .rstn(rstn),
        .trig(wrap_event && ctrl_reg.count_report_select == RCT_REP_FAULT_WRAP),
        .busy(wrap_busy)
    );

    // Open-drain pins: drive low unless releasing
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ripple_pulse_out_o <= 1'b0;
            ripple_pulse_out_oe <= 1'b1;
            fault_alert_n_o <= 1'b0;
            fault_alert_n_oe <= 1'b0;
        end
        else
        begin
            ripple_pulse_out_o <= 1'b0;
            // R16 released (high) during the pulse
            ripple_pulse_out_oe <= !rip_busy;
            fault_alert_n_o <= 1'b0;
            // R5 fault low on threshold only for code 10
            fault_alert_n_oe <= (ctrl_reg.count_report_select == RCT_REP_FAULT_THR && reached_reg) || wrap_busy;
        end
    end

endmodule

// [test/rct_ripple_counter_chk.sv]
// Port-level assertions for the ripple counter block
`timescale 1ns/10ps
module rct_ripple_counter_chk
    import rct_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ripple_pulse_out_o,
    input wire logic ripple_pulse_out_oe,
    input wire logic fault_alert_n_o,
    input wire logic fault_alert_n_oe,
    input wire rct_ctrl_s ctrl_out,
    input wire rct_scale_s scale_out,
    input wire logic [7:0] motor_conductance
);
    localparam logic [13:0] COND_EXP [4] = '{14'h0002, 14'h0040, 14'h0400, 14'h2000};
    logic wr_done;
    int rel_cnt;
    // Completed write on the register bus
    assign wr_done = psel && penable && pready && pwrite;
    // Cycles the ripple wire has been released
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rel_cnt <= 0;
        else
            rel_cnt <= ripple_pulse_out_oe ? 0 : rel_cnt + 1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // One wait state, then ready
    sequence s_access;
        !pready ##1 pready;
    endsequence
    a_bus_wait: assert property (psel && !penable |=> s_access)
        else $error("late ready");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr > RCT_OFF_NRT))
        else $error("bad pslverr");
    a_pins_low_only: assert property (!ripple_pulse_out_o && !fault_alert_n_o)
        else $error("open-drain pin drives high");
    a_pulse_width: assert property ($rose(ripple_pulse_out_oe) |-> rel_cnt >= RCT_PULSE_CYCLES)
        else $error("pulse short");
    a_corr_silent: assert property (ctrl_out.correction_disable && ripple_pulse_out_oe |=> ripple_pulse_out_oe)
        else $error("pulse while off");
    a_fault_quiet: assert property ((ctrl_out.count_report_select == RCT_REP_HOLD) [*2] |-> !fault_alert_n_oe)
        else $error("fault driven in hold mode");
    a_ctrl_copy: assert property (wr_done && paddr == RCT_OFF_CTRL |-> ##2 ctrl_out == $past(pwdata[6:0], 2))
        else $error("control copy wrong");
    a_cond_decode: assert property (wr_done && paddr == RCT_OFF_MODEL |-> ##2
        scale_out.conductance_mult == COND_EXP[$past(pwdata[9:8], 2)] && motor_conductance == $past(pwdata[7:0], 2))
        else $error("conductance decode wrong");
endmodule
bind rct_ripple_counter rct_ripple_counter_chk chk_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .ripple_pulse_out_o(ripple_pulse_out_o), .ripple_pulse_out_oe(ripple_pulse_out_oe),
    .fault_alert_n_o(fault_alert_n_o), .fault_alert_n_oe(fault_alert_n_oe), .ctrl_out(ctrl_out),
    .scale_out(scale_out), .motor_conductance(motor_conductance));

// [test/rct_host_model.sv]
// Host-side model: pulled-up open-drain wires and a pulse counter
`timescale 1ns/10ps
module rct_host_model
(
    input wire logic clk,
    input wire logic rp_oe,
    input wire logic rp_o,
    input wire logic fa_oe,
    input wire logic fa_o,
    output logic rp_pin,
    output logic fault_n_pin,
    output int pulses,
    output int width
);
    int hi;
    // Pull-ups lift each wire whenever the block lets go
    assign rp_pin = rp_oe ? rp_o : 1'b1;
    assign fault_n_pin = fa_oe ? fa_o : 1'b1;
    initial
    begin
        pulses = 0;
        width = 0;
        hi = 0;
    end
    // Count released spans, keep last length
    always @(posedge clk)
    begin
        hi <= (rp_pin === 1'b1) ? hi + 1 : 0;
        if (rp_pin !== 1'b1 && hi != 0)
        begin
            pulses <= pulses + 1;
            width <= hi;
        end
    end
endmodule

// [test/tb.sv]
// Self-checking bench for the ripple counter block
`timescale 1ns/10ps
module tb
    import rct_pkg::*;
;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, bandpass_pulse;
    logic rp_o, rp_oe, fa_o, fa_oe, rp_pin, fault_n_pin;
    logic [7:0] paddr, mc, bc, bq, ml, of;
    logic [31:0] pwdata, prdata;
    logic [15:0] ripple_period;
    rct_ctrl_s ctrl_out;
    rct_scale_s scale_out;
    int bad_count, comparisons, pulses, width;
    localparam int COND[4] = '{2, 64, 1024, 8192};
    localparam int BEMF[4] = '{24 * 256, 24 * 512, 24 * 4096, 24 * 8192};
    localparam int GAIN[4] = '{2, 4, 8, 16};
    localparam int THR[4] = '{2, 8, 16, 64};
    rct_ripple_counter uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bandpass_pulse(bandpass_pulse), .ripple_period(ripple_period), .ripple_pulse_out_o(rp_o),
        .ripple_pulse_out_oe(rp_oe), .fault_alert_n_o(fa_o), .fault_alert_n_oe(fa_oe), .ctrl_out(ctrl_out),
        .scale_out(scale_out), .motor_conductance(mc), .backemf_constant(bc), .bandpass_q(bq),
        .mech_lowpass(ml), .output_filter_cutoff(of));
    rct_host_model host (.clk(clk), .rp_oe(rp_oe), .rp_o(rp_o), .fa_oe(fa_oe), .fa_o(fa_o), .rp_pin(rp_pin),
        .fault_n_pin(fault_n_pin), .pulses(pulses), .width(width));
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict;
        $display("Mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One bus transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
    endtask
    task automatic bp(input int n);
        @(posedge clk);
        bandpass_pulse <= 1'b1;
        @(posedge clk);
        bandpass_pulse <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++)
            rdchk(8'(4 * i), 32'h0000_0000);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
    endtask
    task automatic t_scales;
        for (int c = 0; c < 4; c++)
        begin
            wr(RCT_OFF_MODEL, {6'h00, 2'(c), 8'h5A, 6'h00, 2'(c), 8'hFF});
            wr(RCT_OFF_FILTER, {8'h11, 8'h22, 6'h00, 2'(c), 8'h33});
            repeat (3) @(posedge clk);
            chk(32'(scale_out.conductance_mult), COND[c]);
            chk(32'(scale_out.backemf_mult), BEMF[c]);
            chk(32'(scale_out.bandpass_gain_mult), GAIN[c]);
            chk({mc, bc, bq, ml}, 32'hFF5A_3322);
            chk(32'(of), 32'h0000_0011);
        end
        wr(RCT_OFF_CTRL, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk(32'(ctrl_out.voltage_sense_select), 32'h0000_0001);
    endtask
    task automatic t_count;
        for (int c = 0; c < 4; c++)
        begin
            wr(RCT_OFF_THRESH, {22'h00_0000, 2'(c), 8'h03});
            rdchk(RCT_OFF_NRT, 3 * THR[c]);
        end
        wr(RCT_OFF_THRESH, 32'h0000_0002);
        wr(RCT_OFF_CTRL, 32'h0000_0101);
        repeat (4) bp(20);
        rdchk(RCT_OFF_STATUS, 32'h0000_0000);
        bp(20);
        rdchk(RCT_OFF_STATUS, 32'h0000_0001);
        rdchk(RCT_OFF_COUNT, 32'h0000_0005);
        wr(RCT_OFF_THRESH, 32'h0000_03FF);
        rdchk(RCT_OFF_COUNT, 32'h0000_0005);
        rdchk(RCT_OFF_STATUS, 32'h0000_0001);
        wr(RCT_OFF_CTRL, 32'h0000_0101);
        rdchk(RCT_OFF_COUNT, 32'h0000_0000);
        rdchk(RCT_OFF_STATUS, 32'h0000_0000);
        wr(RCT_OFF_CTRL, 32'h0000_0000);
        bp(20);
        rdchk(RCT_OFF_COUNT, 32'h0000_0000);
    endtask
    task automatic t_pin;
        int p;
        wr(RCT_OFF_CTRL, 32'h0000_0101);
        repeat (2600) @(posedge clk);
        p = pulses;
        bp(2600);
        chk(pulses, p + 1);
        chk(width, RCT_PULSE_CYCLES);
        rdchk(RCT_OFF_COUNT, 32'h0000_0001);
        wr(RCT_OFF_CTRL, 32'h0000_0103);
        bp(2600);
        chk(pulses, p + 1);
    endtask
    task automatic t_blank;
        wr(RCT_OFF_CORR, 32'h0000_000F);
        wr(RCT_OFF_CTRL, 32'h0000_0101);
        ripple_period <= 16'h0050;
        bp(0);
        bp(5);
        bp(50);
        rdchk(RCT_OFF_COUNT, 32'h0000_0001);
        ripple_period <= 16'h0000;
    endtask
    task automatic t_insert;
        logic [31:0] r;
        logic e;
        wr(RCT_OFF_CORR, 32'h0000_0000);
        wr(RCT_OFF_CTRL, 32'h0000_0101);
        ripple_period <= 16'h0028;
        repeat (700) @(posedge clk);
        apb(1'b0, RCT_OFF_COUNT, 32'h0000_0000, r, e);
        chk(32'(r >= 32'h0000_000C), 32'h0000_0001);
        rdchk(RCT_OFF_STATUS, 32'h0000_0000);
        chk(32'(rp_pin), 32'h0000_0001);
        wr(RCT_OFF_CTRL, 32'h0000_0105);
        repeat (3300) @(posedge clk);
        rdchk(RCT_OFF_STATUS, 32'h0000_0002);
        chk(32'(rp_pin), 32'h0000_0000);
        ripple_period <= 16'h0000;
    endtask
    task automatic t_fault;
        wr(RCT_OFF_THRESH, 32'h0000_0001);
        wr(RCT_OFF_CTRL, 32'h0000_0121);
        repeat (2) bp(20);
        chk(32'(fault_n_pin), 32'h0000_0001);
        bp(20);
        chk(32'(fault_n_pin), 32'h0000_0000);
        wr(RCT_OFF_CTRL, 32'h0000_0101);
    endtask
    // Main sequence
    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        bandpass_pulse = 1'b0;
        ripple_period = 16'h0000;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_scales;
        t_count;
        t_pin;
        t_blank;
        t_insert;
        t_fault;
        print_verdict;
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        print_verdict;
    end
endmodule
